// ===== core/pulse_timer.v
/*
 One per-section reset pulse timer: a start pulse loads a count and
 the busy flag stays high until it runs out.
 Assumes start and clock on the same domain, synchronous reset.
*/
`timescale 1ns/1ps
module pulse_timer #(
  parameter [7:0] LENGTH = 8'h04
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire start_i,
  output reg busy_o
);
  reg [7:0] count;
  always @(posedge clk_i) begin
    if (rst_i) begin
      count <= 8'h00;
      busy_o <= 1'b0;
    end else if (start_i) begin
      // Restart while busy just stretches the pulse
      count <= LENGTH;
      busy_o <= 1'b1;
    end else if (count > 8'h01) begin
      count <= count - 8'h01;
    end else begin
      count <= 8'h00;
      busy_o <= 1'b0;
    end
  end
endmodule

// ===== core/sw_reset_ctrl.v
/*
 Software reset controller: one request register over classic Wishbone,
 three self-clearing request bits driving section reset pulses.
 Assumes a single 10 MHz clock and synchronous active-high reset; the
 card detect logic lives elsewhere and is never given these resets.
*/
`timescale 1ns/1ps
`include "swrst_regs.vh"
module sw_reset_ctrl #(
  parameter [31:0] CAP_VALUE = 32'h0000_0000
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire [9:0] adr_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  // Section resets
  output reg all_reset_o,
  output reg cmd_reset_o,
  output reg dat_reset_o,
  // Flag clears towards status registers
  output reg clr_cmd_inhibit_o,
  output reg clr_cmd_complete_o,
  output reg clr_data_flags_o,
  // Capability contents
  output reg cap_valid_o,
  output reg [31:0] cap_o
);
  // ****************************************
  // Bus decode
  // ****************************************
  // Register is one byte lane of its 32-bit word; other lanes are ignored
  localparam [9:0] RST_ADDR = `SW_RESET_REQUEST_ADDR;
  localparam [9:0] CAP_ADDR = `CAPABILITY_ADDR;
  localparam integer LANE_LSB = 8 * RST_ADDR[1:0];
  localparam [1:0] CAP_IDLE = 2'b00;
  localparam [1:0] CAP_WAIT = 2'b01;
  localparam [1:0] CAP_LOAD = 2'b10;
  reg [1:0] cap_state;
  reg [1:0] next_cap_state;
  reg [7:0] cap_count;
  reg [7:0] next_cap_count;
  reg cap_loaded;
  reg load_done;
  reg next_ack;
  reg next_err;
  reg [31:0] next_dat;
  wire req = cyc_i & stb_i & ~ack_o & ~err_o;
  wire hit_rst = (adr_i[9:2] == RST_ADDR[9:2]);
  wire hit_cap = (adr_i[9:2] == CAP_ADDR[9:2]);
  wire hit_any = hit_rst | hit_cap;
  wire wr_rst = req & we_i & hit_rst & sel_i[RST_ADDR[1:0]];
  wire rd_rst = req & ~we_i & hit_rst;
  wire rd_cap = req & ~we_i & hit_cap;
  // Reserved bits of the written byte are never looked at
  wire [`RST_FIELD_W-1:0] wr_bits = dat_i[LANE_LSB +: `RST_FIELD_W];
  wire [`RST_FIELD_W-1:0] start;
  wire [`RST_FIELD_W-1:0] busy;
  wire [`RST_FIELD_W-1:0] clear;
  wire [`RST_FIELD_W-1:0] live;
  wire full_block = all_reset_o | start[`RST_ALL_BIT];
  wire full_active = busy[`RST_ALL_BIT] | start[`RST_ALL_BIT];
  wire cap_busy = (cap_state != CAP_IDLE);

  // ****************************************
  // Section pulse timers
  // ****************************************
  assign start[`RST_ALL_BIT] = wr_rst & wr_bits[`RST_ALL_BIT];
  // Full reset owns both paths, so it blocks their own pulses
  assign start[`RST_CMD_BIT] = wr_rst & wr_bits[`RST_CMD_BIT] & ~full_block;
  assign start[`RST_DAT_BIT] = wr_rst & wr_bits[`RST_DAT_BIT] & ~full_block;

  genvar g;
  generate
    for (g = 0; g < `RST_FIELD_W; g = g + 1) begin : sections
      if (g == `RST_ALL_BIT) begin : full
        assign clear[g] = rst_i;
        assign live[g] = busy[g] | start[g];
      end else begin : part
        // A full reset cancels a running path pulse
        assign clear[g] = rst_i | start[`RST_ALL_BIT];
        assign live[g] = (busy[g] | start[g]) & ~start[`RST_ALL_BIT];
      end
      pulse_timer #(
        .LENGTH(g == `RST_ALL_BIT ? `ALL_PULSE_CYCLES :
                (g == `RST_CMD_BIT ? `CMD_PULSE_CYCLES : `DAT_PULSE_CYCLES))
      ) i_pulse_timer (
        .clk_i(clk_i),
        .rst_i(clear[g]),
        .start_i(start[g]),
        .busy_o(busy[g])
      );
    end
  endgenerate

  // ****************************************
  // Capability load after full reset
  // ****************************************
  // Full load count only the first time; repeats reload the contents one cycle after the pulse
  wire [7:0] cap_reload = cap_loaded ? 8'h01 : `CAP_LOAD_CYCLES;
  always @* begin
    next_cap_state = cap_state;
    next_cap_count = cap_count;
    load_done = 1'b0;
    case (cap_state)
      CAP_IDLE: begin
        if (full_active) begin
          next_cap_state = CAP_WAIT;
          next_cap_count = cap_reload;
        end
      end
      CAP_WAIT, CAP_LOAD: begin
        if (full_active) begin
          next_cap_state = CAP_WAIT;
          next_cap_count = cap_reload;
        end else if (cap_count > 8'h01) begin
          next_cap_state = CAP_LOAD;
          next_cap_count = cap_count - 8'h01;
        end else begin
          next_cap_state = CAP_IDLE;
          next_cap_count = 8'h00;
          load_done = 1'b1;
        end
      end
      default: begin
        next_cap_state = CAP_IDLE;
        next_cap_count = 8'h00;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cap_state <= CAP_IDLE;
      cap_count <= 8'h00;
      cap_loaded <= 1'b0;
      cap_valid_o <= 1'b0;
      cap_o <= 32'h0000_0000;
    end else begin
      cap_state <= next_cap_state;
      cap_count <= next_cap_count;
      if (full_active) begin
        cap_valid_o <= cap_loaded;
      end else if (load_done) begin
        cap_loaded <= 1'b1;
        cap_valid_o <= 1'b1;
        cap_o <= CAP_VALUE;
      end
    end
  end

  // ****************************************
  // Section reset outputs
  // ****************************************
  // Full reset holds until capabilities are valid, not just the pulse
  wire next_all = live[`RST_ALL_BIT] | cap_busy;
  always @(posedge clk_i) begin
    if (rst_i) begin
      all_reset_o <= 1'b0;
      cmd_reset_o <= 1'b0;
      dat_reset_o <= 1'b0;
      clr_cmd_inhibit_o <= 1'b0;
      clr_cmd_complete_o <= 1'b0;
      clr_data_flags_o <= 1'b0;
    end else begin
      // Card detect has no input here, so it is never reset
      all_reset_o <= next_all;
      // Command reset stays local to the command path
      cmd_reset_o <= live[`RST_CMD_BIT];
      clr_cmd_inhibit_o <= live[`RST_CMD_BIT];
      clr_cmd_complete_o <= live[`RST_CMD_BIT];
      dat_reset_o <= live[`RST_DAT_BIT];
      clr_data_flags_o <= live[`RST_DAT_BIT];
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // Request bits read back as the live reset state, so polling sees 1
  wire [7:0] rst_view = {5'h00, dat_reset_o, cmd_reset_o, all_reset_o};
  wire [31:0] rst_word = {24'h000000, rst_view} << LANE_LSB;
  wire [31:0] cap_word = {cap_valid_o, 31'h0000_0000} | (cap_valid_o ? cap_o : 32'h0000_0000);
  always @* begin
    next_ack = 1'b0;
    next_err = 1'b0;
    next_dat = 32'h0000_0000;
    if (req) begin
      next_ack = hit_any;
      next_err = ~hit_any;
      if (rd_rst) begin
        next_dat = rst_word;
      end else if (rd_cap) begin
        next_dat = cap_word;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= next_ack;
      err_o <= next_err;
      dat_o <= next_dat;
    end
  end
endmodule

// ===== core/swrst_regs.vh
/*
 Offsets, field positions, reset values and timing counts for the
 software reset controller. Assumes inclusion by bare name.
*/
`ifndef SWRST_REGS_VH
`define SWRST_REGS_VH
// Byte offset of the request register; low bits pick its lane on the bus
`define SW_RESET_REQUEST_ADDR 10'h02F
// Own register: capability contents and valid flag, word aligned
`define CAPABILITY_ADDR 10'h0C0
`define RST_ALL_BIT 0
`define RST_CMD_BIT 1
`define RST_DAT_BIT 2
`define RST_FIELD_W 3
`define RST_REG_RESET 8'h00
// Pulse lengths in controller clock cycles
`define ALL_PULSE_CYCLES 8'h10
`define CMD_PULSE_CYCLES 8'h04
`define DAT_PULSE_CYCLES 8'h04
// Cycles to load capability contents after a full reset pulse
`define CAP_LOAD_CYCLES 8'h08
`endif

// ===== verif/host_software_reset_control_bench.sv
/* Self-checking bench for sw_reset_ctrl.
 Assumes checker and design compiled first. */
`timescale 1ns/1ps
module host_software_reset_control_bench;
  reg clk_i, rst_i, cyc_i, stb_i, we_i, e;
  reg [3:0] sel_i;
  reg [9:0] adr_i;
  reg [31:0] dat_i, q;
  wire [31:0] dat_o, cap_o;
  wire ack_o, err_o, all_reset_o, cmd_reset_o, dat_reset_o, cap_valid_o;
  wire clr_cmd_inhibit_o, clr_cmd_complete_o, clr_data_flags_o;
  integer error_cnt = 0, samples_checked = 0, n;
  sw_reset_ctrl #(.CAP_VALUE(32'h0000_1234)) i_sw_reset_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .all_reset_o(all_reset_o), .cmd_reset_o(cmd_reset_o),
    .dat_reset_o(dat_reset_o), .clr_cmd_inhibit_o(clr_cmd_inhibit_o),
    .clr_cmd_complete_o(clr_cmd_complete_o), .clr_data_flags_o(clr_data_flags_o),
    .cap_valid_o(cap_valid_o), .cap_o(cap_o)
  );
  task chk(input [31:0] s, input [31:0] x);
    samples_checked = samples_checked + 1;
    if (s !== x) begin
      error_cnt = error_cnt + 1;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task wb(input [9:0] a, input w, input [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // Polls until masked bits read zero, bounded
  task poll(input [31:0] m);
    n = 0;
    q = m;
    while ((q & m) != 0 && n < 100) begin
      wb(10'h02C, 1'b0, 32'h0000_0000);
      n = n + 1;
    end
    chk(q & m, 32'h0000_0000);
  endtask
  // Register is byte lane 3 of word 0x02C; other lanes carry no request
  task t_rsvd;
    chk({all_reset_o, cmd_reset_o, dat_reset_o, cap_valid_o}, 4'h0);
    wb(10'h02C, 1'b1, 32'hF8FF_FFFF);
    chk({all_reset_o, cmd_reset_o, dat_reset_o}, 3'h0);
    wb(10'h02C, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask
  task t_all;
    chk(cap_valid_o, 1'b0);
    wb(10'h02C, 1'b1, 32'h0100_0000);
    chk({all_reset_o, cmd_reset_o, dat_reset_o}, 3'h4);
    wb(10'h02C, 1'b0, 32'h0000_0000);
    chk(q, 32'h0100_0000);
    poll(32'h0100_0000);
    wb(10'h0C0, 1'b0, 32'h0000_0000);
    chk(q, 32'h8000_1234);
    wb(10'h02C, 1'b1, 32'h0700_0000);
    chk({all_reset_o, cmd_reset_o, dat_reset_o}, 3'h4);
    chk(cap_valid_o, 1'b1);
    poll(32'h0700_0000);
    chk(cap_o, 32'h0000_1234);
  endtask
  task t_cmd;
    wb(10'h02C, 1'b1, 32'h0200_0000);
    chk({all_reset_o, cmd_reset_o, dat_reset_o}, 3'h2);
    chk({clr_cmd_inhibit_o, clr_cmd_complete_o}, 2'h3);
    poll(32'h0200_0000);
  endtask
  task t_dat;
    wb(10'h02C, 1'b1, 32'h0400_0000);
    chk({cmd_reset_o, dat_reset_o, clr_data_flags_o}, 3'h3);
    poll(32'h0400_0000);
  endtask
  task t_bad;
    wb(10'h100, 1'b1, 32'h0100_0000);
    chk({e, all_reset_o}, 2'h2);
    sel_i <= 4'h7;
    wb(10'h02C, 1'b1, 32'h0100_0000);
    sel_i <= 4'hF;
    chk({e, all_reset_o}, 2'h0);
  endtask
  task finish_test;
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {3'h0, 10'h000, 32'h0000_0000, 4'hF};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rsvd;
    t_all;
    t_cmd;
    t_dat;
    t_bad;
    finish_test;
  end
  // Watchdog, well beyond the longest poll chain
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt = error_cnt + 1;
    finish_test;
  end
endmodule

// ===== verif/sw_reset_checker.sv
/* Port assertions for sw_reset_ctrl.
 Assumes one clock, rst_i synchronous active high. */
`timescale 1ns/1ps
module sw_reset_checker (
  // Bus side
  input wire clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o,
  input wire [3:0] sel_i,
  input wire [9:0] adr_i,
  input wire [31:0] dat_i, dat_o, cap_o,
  // Section side
  input wire all_reset_o, cmd_reset_o, dat_reset_o, cap_valid_o,
  input wire clr_cmd_inhibit_o, clr_cmd_complete_o, clr_data_flags_o
);
  wire tk = cyc_i && stb_i && !ack_o && !err_o;
  wire rst_hit = adr_i[9:2] == 8'h0B;
  wire wr = tk && we_i && sel_i[3] && rst_hit;
  wire map = rst_hit || adr_i[9:2] == 8'h30;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_all_req; wr && dat_i[24]; endsequence
  sequence s_cmd_req; wr && dat_i[25] && !dat_i[24] && !all_reset_o; endsequence
  sequence s_dat_req; wr && dat_i[26] && !dat_i[24] && !all_reset_o; endsequence
  ack_mapped_a: assert property (tk && map |=> ack_o && !err_o) else $error("no ack");
  err_unmapped_a: assert property (tk && !map |=> err_o && !ack_o) else $error("no err");
  all_start_a: assert property (s_all_req |=> all_reset_o) else $error("no full reset");
  cmd_start_a: assert property (s_cmd_req |=> cmd_reset_o) else $error("no cmd reset");
  dat_start_a: assert property (s_dat_req |=> dat_reset_o) else $error("no data reset");
  full_cancel_a: assert property (s_all_req |=> !cmd_reset_o && !dat_reset_o)
    else $error("path reset kept");
  cmd_end_a: assert property ($rose(cmd_reset_o) |-> ##[1:8] !cmd_reset_o)
    else $error("cmd reset stuck");
  cmd_flags_a: assert property (clr_cmd_inhibit_o == cmd_reset_o
    && clr_cmd_complete_o == cmd_reset_o) else $error("cmd flag clear wrong");
  dat_flags_a: assert property (clr_data_flags_o == dat_reset_o)
    else $error("data flag clear wrong");
  cap_ready_a: assert property ($fell(all_reset_o) |-> cap_valid_o)
    else $error("cap not valid");
  cap_keep_a: assert property ($past(cap_valid_o) |-> $stable(cap_o))
    else $error("cap changed");
  rsvd_zero_a: assert property (ack_o && !we_i && rst_hit
    |-> dat_o[31:27] == 0 && dat_o[23:0] == 0) else $error("reserved bits set");
endmodule
bind sw_reset_ctrl sw_reset_checker i_sw_reset_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .ack_o(ack_o), .err_o(err_o), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .cap_o(cap_o), .all_reset_o(all_reset_o), .cmd_reset_o(cmd_reset_o),
  .dat_reset_o(dat_reset_o), .cap_valid_o(cap_valid_o),
  .clr_cmd_inhibit_o(clr_cmd_inhibit_o), .clr_cmd_complete_o(clr_cmd_complete_o),
  .clr_data_flags_o(clr_data_flags_o)
);
